// ==== hdl/sfc_params.svh ====
// Purpose: constants for the serial flash command and status link
// Assumes: 8-bit opcodes, 24-bit addresses
// Notes: included by both ends
`ifndef SFC_PARAMS_SVH
`define SFC_PARAMS_SVH
`define SFC_OP_WRITE_STATUS   8'h01
`define SFC_OP_PROGRAM        8'h02
`define SFC_OP_READ           8'h03
`define SFC_OP_WRITE_DISABLE  8'h04
`define SFC_OP_READ_STATUS    8'h05
`define SFC_OP_WRITE_ENABLE   8'h06
`define SFC_OP_SECTOR_ERASE   8'h20
`define SFC_OP_ENABLE_STATUS  8'h50
`define SFC_OP_BLOCK_ERASE    8'h52
`define SFC_OP_CHIP_ERASE     8'h60
`define SFC_OP_READ_ID        8'h90
`define SFC_OP_READ_ID_ALT    8'hAB
`define SFC_OP_AUTO_PROGRAM   8'hAF
`define SFC_BIT_BUSY          0
`define SFC_BIT_WEL           1
`define SFC_BIT_PL_LO         2
`define SFC_BIT_PL_HI         3
`define SFC_BIT_AAI           6
`define SFC_BIT_LOCK          7
`define SFC_STATUS_RESET      8'h0C
`define SFC_QUARTER_BASE      24'h0C0000
`define SFC_HALF_BASE         24'h080000
`define SFC_TOP_ADDR          24'h0FFFFF
`define SFC_BUSY_CYCLES       16'h0040
`define SFC_SCK_HALF_DIV      8'h04
`define SFC_REG_CTRL          4'h0
`define SFC_REG_TXW           4'h4
`define SFC_REG_STAT          4'h8
`define SFC_REG_RXW           4'hC
`endif

// ==== hdl/sfc_pkg.sv ====
// Purpose: shared types of the serial flash command link
// Assumes: constants come from sfc_params.svh
// Notes: types only
package sfc_pkg;
  typedef enum logic [3:0] {
    SFC_IDLE = 4'b0001,
    SFC_CMD  = 4'b0010,
    SFC_ARG  = 4'b0100,
    SFC_OUT  = 4'b1000
  } sfc_phase_e;
  typedef logic [7:0] sfc_byte_t;
endpackage

// ==== hdl/sfc_link_if.sv ====
// Purpose: spi pins between controller and flash device
// Assumes: serial output is a tri-state pin resolved here
// Notes: one modport per end
`timescale 1ns/1ps
interface sfc_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so_out;
  logic so_oe;
  logic wp_n;
  logic so;
  assign so = so_oe ? so_out : 1'b1;
  modport device (input cs_n, input sck, input si, input wp_n, output so_out, output so_oe);
  modport host (output cs_n, output sck, output si, output wp_n, input so);
endinterface

// ==== hdl/sfc_sync.sv ====
// Purpose: two-flop synchroniser for a bus of pins
// Assumes: inputs asynchronous to core_clk
// Notes: frozen while clk_en is low
`timescale 1ns/1ps
module sfc_sync #(
  parameter int W = 4
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] init,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] q_x;
  // flops hold pins xor idle level, so reset reads as idle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q_x  <= '0;
    end else if (clk_en) begin
      meta <= d ^ init;
      q_x  <= meta;
    end
  end
  assign q = q_x ^ init;
endmodule

// ==== hdl/sfc_device.sv ====
// Purpose: flash end: opcode decoder and status byte
// Assumes: pins sampled by core_clk via two flops
// Notes: array itself absent; busy is a timed stand-in
// Behaviour
// - bit 0 busy during program or erase
// - bit 1 latch; program/erase needs it
// - latch clears on disable and on accepting program/erase; auto-program clears it only at the top address
// - protect level bits 2,3, reset ones
// - bits 4,5 read zero
// - bit 6 shows auto-increment mode
// - lock with wp low freezes protect bits
// - wp high makes lock irrelevant
// - protect levels map to array regions
// - chip erase only when unprotected
// - only status reads while busy
// - host sends write enable first
// - falling select starts; bytes on rising sck
// - execution starts on select release
// - early release aborts instruction
// - read, status, id opcodes and output
// - erase opcodes, output stays off
// - program opcodes with address, data
// - enable-status and write-status opcodes
// - all bytes msb first
// - write status only right after enable
// - sample rising, drive after falling
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`include "sfc_params.svh"
`timescale 1ns/1ps
module sfc_device
  import sfc_pkg::*;
#(
  parameter logic [7:0] MAKER_ID  = 8'h5A,
  parameter logic [7:0] PART_ID   = 8'h3C,
  parameter int         BUSY_CYCLES = `SFC_BUSY_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  sfc_link_if.device link,
  output logic      array_busy,
  output logic [7:0] status_view
);
  // maker and part id values are arbitrary
  logic [2:0] pins;
  logic       cs_s, sck_s, si_s, sck_d, cs_d;
  logic       wp_s;
  logic       sck_rise, sck_fall, cs_fall, cs_rise;
  sfc_phase_e phase;
  logic [7:0] shreg, opcode, txreg;
  logic [2:0] bitcnt;
  logic [2:0] bytecnt;
  logic       byte_done;
  logic [23:0] addr;
  logic [7:0] wdata;
  logic       write_enable_latch, busy, auto_increment_program, pl_lo, pl_hi, lock, ews_armed, ews_prev;
  logic [15:0] busy_cnt;
  logic [7:0] status;
  logic       protected_hit;
  logic       armed_now;

  sfc_sync #(.W(4)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .d        ({link.cs_n, link.sck, link.si, link.wp_n}),
    .init     (4'h8),
    .q        ({cs_s, sck_s, si_s, wp_s})
  );
  assign pins = {cs_s, sck_s, si_s};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_d <= 1'b0;
      cs_d  <= 1'b1;
    end else if (clk_en) begin
      sck_d <= pins[1];
      cs_d  <= pins[2];
    end
  end
  assign sck_rise  = !cs_s && sck_s && !sck_d;
  assign sck_fall  = !cs_s && !sck_s && sck_d;
  assign cs_fall   = cs_d && !cs_s;
  assign cs_rise   = !cs_d && cs_s;
  assign byte_done = sck_rise && (bitcnt == 3'h7);

  assign status = {lock, auto_increment_program, 2'b00, pl_hi, pl_lo, write_enable_latch, busy};

  always_comb begin
    case ({pl_hi, pl_lo})
      2'b01:   protected_hit = (addr >= `SFC_QUARTER_BASE);
      2'b10:   protected_hit = (addr >= `SFC_HALF_BASE);
      2'b11:   protected_hit = 1'b1;
      default: protected_hit = 1'b0;
    endcase
  end

  // serial receive and phase tracking
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase   <= SFC_IDLE;
      shreg   <= 8'h00;
      opcode  <= 8'h00;
      bitcnt  <= 3'h0;
      bytecnt <= 3'h0;
      addr    <= 24'h000000;
      wdata   <= 8'h00;
    end else if (clk_en) begin
      if (cs_fall) begin
        phase   <= SFC_CMD;
        bitcnt  <= 3'h0;
        bytecnt <= 3'h0;
      end else if (cs_s) begin
        phase <= SFC_IDLE;
      end else if (sck_rise) begin
        shreg  <= {shreg[6:0], pins[0]};
        bitcnt <= bitcnt + 3'h1;
        if (byte_done) begin
          if (bytecnt != 3'h7)
            bytecnt <= bytecnt + 3'h1;
          case (phase)
            SFC_CMD: begin
              opcode <= {shreg[6:0], pins[0]};
              phase  <= SFC_ARG;
            end
            SFC_ARG: begin
              if (bytecnt <= 3'h3 && bytecnt != 3'h0)
                addr <= {addr[15:0], shreg[6:0], pins[0]};
              if ((bytecnt == 3'h4) || (opcode == `SFC_OP_WRITE_STATUS && bytecnt == 3'h1))
                wdata <= {shreg[6:0], pins[0]};
            end
            default: phase <= phase;
          endcase
        end
      end
    end
  end

  assign armed_now = ews_prev && (opcode == `SFC_OP_WRITE_STATUS) && (bytecnt == 3'h2);

  // instruction execution at select release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      write_enable_latch       <= 1'b0;
      busy      <= 1'b0;
      auto_increment_program       <= 1'b0;
      pl_lo     <= 1'b1;
      pl_hi     <= 1'b1;
      lock      <= 1'b0;
      busy_cnt  <= 16'h0000;
      ews_armed <= 1'b0;
      ews_prev  <= 1'b0;
    end else if (clk_en) begin
      if (busy) begin
        if (busy_cnt == 16'h0001)
          busy <= 1'b0;
        busy_cnt <= busy_cnt - 16'h0001;
      end
      if (cs_fall) begin
        ews_prev  <= ews_armed;
        ews_armed <= 1'b0;
      end
      // early release leaves bitcnt nonzero: aborted
      if (cs_rise && phase == SFC_ARG && bitcnt == 3'h0 && !busy) begin
        case (opcode)
          `SFC_OP_WRITE_ENABLE:  if (bytecnt == 3'h1) write_enable_latch <= 1'b1;
          `SFC_OP_WRITE_DISABLE: if (bytecnt == 3'h1) begin
            write_enable_latch <= 1'b0;
            auto_increment_program <= 1'b0;
          end
          `SFC_OP_ENABLE_STATUS: if (bytecnt == 3'h1) ews_armed <= 1'b1;
          `SFC_OP_WRITE_STATUS: if (armed_now && (wp_s || !lock)) begin
            pl_lo <= wdata[`SFC_BIT_PL_LO];
            pl_hi <= wdata[`SFC_BIT_PL_HI];
            lock  <= wdata[`SFC_BIT_LOCK];
          end
          `SFC_OP_CHIP_ERASE: if (bytecnt == 3'h1 && write_enable_latch) begin
            write_enable_latch <= 1'b0;
            if (!pl_hi && !pl_lo) begin
              busy     <= 1'b1;
              busy_cnt <= 16'(BUSY_CYCLES);
            end
          end
          `SFC_OP_SECTOR_ERASE, `SFC_OP_BLOCK_ERASE: if (bytecnt == 3'h4 && write_enable_latch) begin
            write_enable_latch <= 1'b0;
            if (!protected_hit) begin
              busy     <= 1'b1;
              busy_cnt <= 16'(BUSY_CYCLES);
            end
          end
          `SFC_OP_PROGRAM: if (bytecnt == 3'h5 && write_enable_latch) begin
            write_enable_latch <= 1'b0;
            if (!protected_hit) begin
              busy     <= 1'b1;
              busy_cnt <= 16'(BUSY_CYCLES);
            end
          end
          `SFC_OP_AUTO_PROGRAM: if (bytecnt == 3'h5 && write_enable_latch && !protected_hit) begin
            auto_increment_program      <= 1'b1;
            busy     <= 1'b1;
            busy_cnt <= 16'(BUSY_CYCLES);
            if (addr == `SFC_TOP_ADDR) begin
              write_enable_latch <= 1'b0;
              auto_increment_program <= 1'b0;
            end
          end
          default: write_enable_latch <= write_enable_latch;
        endcase
      end
    end
  end

  // serial output after falling sck
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      txreg       <= 8'h00;
      link.so_out <= 1'b0;
      link.so_oe  <= 1'b0;
    end else if (clk_en) begin
      if (cs_s) begin
        link.so_oe <= 1'b0;
      end else if (byte_done) begin
        if ((phase == SFC_CMD && {shreg[6:0], pins[0]} == `SFC_OP_READ_STATUS)
            || (phase == SFC_ARG && opcode == `SFC_OP_READ_STATUS)) begin
          txreg <= status;
          link.so_oe <= 1'b1;
        end else if (phase == SFC_ARG && bytecnt == 3'h3 && !busy
                     && (opcode == `SFC_OP_READ_ID || opcode == `SFC_OP_READ_ID_ALT)) begin
          txreg <= pins[0] ? PART_ID : MAKER_ID;  // id address bit 0 picks
          link.so_oe <= 1'b1;
        end else if (phase == SFC_ARG && bytecnt == 3'h3 && !busy && opcode == `SFC_OP_READ) begin
          txreg <= 8'hFF;  // erased array stand-in
          link.so_oe <= 1'b1;
        end
      end else if (sck_fall && link.so_oe) begin
        link.so_out <= txreg[7];
        txreg       <= {txreg[6:0], txreg[7]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      array_busy  <= 1'b0;
      status_view <= `SFC_STATUS_RESET;
    end else if (clk_en) begin
      array_busy  <= busy;
      status_view <= status;
    end
  end
endmodule

// ==== hdl/sfc_host.sv ====
// Purpose: spi master controller reached over axi4-lite
// Assumes: one byte per command write, select held by ctrl
// Notes: sck divided from core_clk, mode 0
`include "sfc_params.svh"
`timescale 1ns/1ps
module sfc_host
  import sfc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  sfc_link_if.host         link
);
  logic       aw_hold, w_hold, so_m, so_s;
  logic [3:0] aw_a;
  logic [31:0] w_d;
  logic [7:0] tx, rx;
  logic [2:0] nbit;
  logic [7:0] div;
  logic       run;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      so_m <= 1'b1;
      so_s <= 1'b1;
    end else if (clk_en) begin
      so_m <= link.so;
      so_s <= so_m;
    end
  end

  // write channel: address and data in either order
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold <= 1'b0;
      w_hold  <= 1'b0;
      aw_a    <= 4'h0;
      w_d     <= 32'h00000000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end else if (clk_en) begin
      s_axi_awready <= !aw_hold && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready  <= !w_hold && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_a    <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_d    <= s_axi_wdata;
      end
      if (aw_hold && w_hold && !s_axi_bvalid && !(aw_a == `SFC_REG_TXW && run)) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_a == `SFC_REG_CTRL || aw_a == `SFC_REG_TXW) ? 2'b00 : 2'b10;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control pins and byte shifter
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      link.cs_n <= 1'b1;
      link.wp_n <= 1'b1;
      link.sck  <= 1'b0;
      link.si   <= 1'b0;
      tx   <= 8'h00;
      rx   <= 8'h00;
      nbit <= 3'h0;
      div  <= 8'h00;
      run  <= 1'b0;
    end else if (clk_en) begin
      if (aw_hold && w_hold && !s_axi_bvalid && aw_a == `SFC_REG_CTRL) begin
        link.cs_n <= !w_d[0];
        link.wp_n <= !w_d[1];
        if (!w_d[0]) begin
          link.sck <= 1'b0;
          run      <= 1'b0;  // release cuts a byte short
        end
      end else if (aw_hold && w_hold && !s_axi_bvalid && !run && aw_a == `SFC_REG_TXW) begin
        tx      <= w_d[7:0];
        link.si <= w_d[7];
        nbit    <= 3'h0;
        div     <= 8'h00;
        run     <= 1'b1;
      end else if (run) begin
        if (div == `SFC_SCK_HALF_DIV) begin
          div <= 8'h00;
          if (!link.sck) begin
            link.sck <= 1'b1;
          end else begin
            link.sck <= 1'b0;
            rx       <= {rx[6:0], so_s};  // late in high phase: so path lags
            tx       <= {tx[6:0], 1'b0};
            link.si  <= tx[6];
            nbit     <= nbit + 3'h1;
            if (nbit == 3'h7) run <= 1'b0;
          end
        end else begin
          div <= div + 8'h01;
        end
      end
    end
  end

  // read channel
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= 2'b00;
    end else if (clk_en) begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'b00;
        case (s_axi_araddr)
          `SFC_REG_CTRL: s_axi_rdata <= {30'h0, !link.wp_n, !link.cs_n};
          `SFC_REG_STAT: s_axi_rdata <= {31'h0, run};
          `SFC_REG_RXW:  s_axi_rdata <= {24'h0, rx};
          `SFC_REG_TXW:  s_axi_rdata <= {24'h0, tx};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ==== bench/sfc_link_checker.sv ====
// Purpose: pin checks on the flash link
// Assumes: mode 0 host, sck of 5-cycle halves
// Notes: sits beside the interface
`timescale 1ns/1ps
module sfc_link_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_out,
  input wire logic so_oe
);
  logic [2:0] hi_cnt;
  logic [5:0] bit_cnt;
  logic       sck_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // cycles since select release
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) hi_cnt <= 3'h0;
    else if (!cs_n) hi_cnt <= 3'h0;
    else if (hi_cnt != 3'h7) hi_cnt <= hi_cnt + 3'h1;
  end
  // sck rises within a frame
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q   <= 1'b0;
      bit_cnt <= 6'h00;
    end else begin
      sck_q <= sck;
      if (cs_n) bit_cnt <= 6'h00;
      else if (sck && !sck_q && bit_cnt != 6'h3F) bit_cnt <= bit_cnt + 6'h01;
    end
  end
  sequence s_high;
    sck [*5] ##1 !sck;
  endsequence
  sequence s_off_byte;
    !so_oe [*8];
  endsequence
  a_sck_high_len: assert property ($rose(sck) |-> s_high)
    else $error("sck high phase wrong length");
  a_si_steady: assert property (sck |-> $stable(si))
    else $error("si moved while sck high");
  a_frame_sck_low: assert property ($fell(cs_n) |-> !sck)
    else $error("frame began with sck high");
  a_opcode_so_off: assert property ($fell(cs_n) |-> s_off_byte)
    else $error("so driven during opcode");
  a_so_after_fall: assert property (so_oe && $changed(so_out) |-> !sck)
    else $error("so changed while sck high");
  a_so_only_sel: assert property (so_oe |-> hi_cnt < 3'h5)
    else $error("so driven while deselected");
  a_oe_after_byte: assert property ($rose(so_oe) |-> bit_cnt >= 6'h08)
    else $error("so driven before a whole byte");
  a_link_quiet: assert property (hi_cnt == 3'h7 |-> !sck && !so_oe)
    else $error("link busy while idle");
endmodule

// ==== bench/test_spi_flash_cmd_status.sv ====
// Purpose: host and flash ends driven over axi4-lite
// Assumes: ctrl 0x0, txw 0x4, stat 0x8, rxw 0xc
// Notes: busy stretched so status reads catch it
`timescale 1ns/1ps
module test_spi_flash_cmd_status;
  localparam logic [7:0] MAKER = 8'h5A; // arbitrary
  localparam logic [7:0] PART  = 8'h3C; // arbitrary
  logic        core_clk      = 1'b0;
  logic        rst_n         = 1'b0;
  logic [3:0]  s_axi_awaddr  = 4'h0;
  logic [3:0]  s_axi_araddr  = 4'h0;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy, wp_lo;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  logic [7:0]  stv, rxb;
  int          n_fail        = 0;
  int          num_checks    = 0;
  sfc_link_if lnk();
  sfc_host sfc_host_i (.core_clk, .rst_n, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .link(lnk.host));
  sfc_device #(.MAKER_ID(MAKER), .PART_ID(PART), .BUSY_CYCLES(400)) sfc_device_i (.core_clk, .rst_n,
    .clk_en(1'b1), .link(lnk.device), .array_busy(busy), .status_view(stv));
  sfc_link_checker sfc_link_checker_i (.core_clk, .rst_n, .cs_n(lnk.cs_n), .sck(lnk.sck), .si(lnk.si),
    .so_out(lnk.so_out), .so_oe(lnk.so_oe));
  task automatic stop_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 4000) begin
      n_fail++;
      $display("BAD %0t wait ran out", $time);
      stop_test();
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 4000);
    tmo(n);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a);
    int n;
    n = 0;
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 4000);
    tmo(n);
    rsp = s_axi_rresp;
    rd  = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask
  task automatic ctl(input logic sel);
    axw(4'h0, {30'h0, wp_lo, sel});
  endtask
  // one byte out, wait for shift end, fetch reply
  task automatic xb(input logic [7:0] t);
    int n;
    n = 0;
    axw(4'h4, {24'h0, t});
    do begin
      axr(4'h8);
      n++;
    end while (rd[0] !== 1'b0 && n < 4000);
    tmo(n);
    axr(4'hC);
    rxb = rd[7:0];
  endtask
  task automatic frm(input logic [39:0] b, input int k);
    ctl(1'b1);
    for (int i = 0; i < k; i++) begin
      xb(b[39-8*i -: 8]);
    end
    ctl(1'b0);
  endtask
  task automatic rdst();
    frm({8'h05, 32'hFFFFFFFF}, 3);
  endtask
  task automatic wst(input logic [7:0] v);
    frm({8'h50, 32'h0}, 1);
    frm({8'h01, v, 24'h0}, 2);
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (busy !== 1'b0 && n < 4000);
    tmo(n);
  endtask
  task automatic t_reset();
    rdst();
    chk(rxb, 8'h0C);
    chk(stv, 8'h0C);
    axr(4'h2);
    chk(rsp, 2'h2);
    axw(4'h2, 32'h0);
    chk(rsp, 2'h2);
  endtask
  task automatic t_latch();
    frm({8'h06, 32'h0}, 1);
    rdst();
    chk(rxb, 8'h0E);
    frm({8'h04, 32'h0}, 1);
    rdst();
    chk(rxb, 8'h0C);
    ctl(1'b1);
    axw(4'h4, 32'h06);
    // release lands in sck low after two bits
    repeat (16) @(posedge core_clk);
    ctl(1'b0);
    rdst();
    chk(rxb, 8'h0C);
  endtask
  task automatic t_lock();
    frm({8'h01, 8'h00, 24'h0}, 2);
    rdst();
    chk(rxb, 8'h0C);
    wst(8'hF0);
    rdst();
    chk(rxb, 8'h80);
    wp_lo = 1'b1;
    wst(8'h0C);
    rdst();
    chk(rxb, 8'h80);
    chk(stv, 8'h80);
    wp_lo = 1'b0;
    wst(8'h04);
    rdst();
    chk(rxb, 8'h04);
  endtask
  task automatic t_region();
    frm({8'h06, 32'h0}, 1);
    frm({8'h02, 24'h0C0000, 8'hA5}, 5);
    rdst();
    chk(rxb[0], 1'b0);
    frm({8'h06, 32'h0}, 1);
    frm({8'h02, 24'h0BFFFF, 8'hA5}, 5);
    rdst();
    chk(rxb[0], 1'b1);
    idle();
    rdst();
    chk(rxb, 8'h04);
    frm({8'h06, 32'h0}, 1);
    frm({8'h60, 32'h0}, 1);
    rdst();
    chk(rxb[0], 1'b0);
  endtask
  task automatic t_ops();
    logic [7:0] op [4];
    op = '{8'h20, 8'h52, 8'h02, 8'hAF};
    wst(8'h00);
    frm({8'h06, 32'h0}, 1);
    frm({8'h60, 32'h0}, 1);
    rdst();
    chk(rxb[0], 1'b1);
    idle();
    frm({8'h02, 24'h0, 8'hA5}, 5);
    rdst();
    chk(rxb, 8'h00);
    for (int i = 0; i < 4; i++) begin
      frm({8'h06, 32'h0}, 1);
      frm({op[i], 24'h001000, 8'h5A}, (i < 2) ? 4 : 5);
      rdst();
      chk(rxb[0], 1'b1);
      idle();
      rdst();
      chk(rxb, (i == 3) ? 8'h42 : 8'h00);
    end
    chk(stv, 8'h42);
    frm({8'h04, 32'h0}, 1);
    rdst();
    chk(rxb, 8'h00);
  endtask
  task automatic t_misc();
    frm({8'hFF, 8'h00, 24'h0}, 2);
    rdst();
    chk(rxb, 8'h00);
    frm({8'h03, 24'h0, 8'hFF}, 5);
    chk(rxb, 8'hFF);
    frm({8'h90, 24'h0, 8'hFF}, 5);
    chk(rxb, MAKER);
    frm({8'hAB, 24'h000001, 8'hFF}, 5);
    chk(rxb, PART);
  endtask
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    wp_lo = 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_latch();
    t_lock();
    t_region();
    t_ops();
    t_misc();
    stop_test();
  end
endmodule
